// [hw/unlock_pkg.sv]
// constants, register map and carrier types for the timed register unlock unit
// assumes a single cpu clock domain and an 8-bit sfr / 16-bit xfr register space
package unlock_pkg;

   // key values written by software
   localparam logic [7:0]  KEY_FIRST              = 8'hAA;
   localparam logic [7:0]  KEY_SECOND             = 8'h55;
   localparam logic [7:0]  KEY_CLOSE              = 8'h00;

   // key registers (sfr space)
   localparam logic [7:0]  SINGLE_USE_KEY_ADDR    = 8'hC7;
   localparam logic [7:0]  TIMED_WINDOW_KEY_ADDR  = 8'hC9;

   // sfr registers guarded by the single-use key
   localparam logic [7:0]  WATCHDOG_CONTROL_ADDR  = 8'hD8;
   localparam logic [7:0]  MEMORY_CONTROL_ADDR    = 8'hC6;
   localparam logic [7:0]  AUXILIARY_CONTROL_ADDR = 8'h9D;

   // sfr registers guarded by the timed key
   localparam logic [7:0]  CLOCK_SELECT_ADDR      = 8'h8F;
   localparam logic [7:0]  WAKEUP_MASK_ADDR       = 8'h9F;

   // xfr registers guarded by the timed key
   localparam int          TIMED_XFR_COUNT        = 11;
   localparam logic [15:0] TIMED_XFR_ADDRS [TIMED_XFR_COUNT] = '{
      16'hA000,   // regulator_trim_reg
      16'hA001,   // osc_current_trim_reg
      16'hA002,   // osc_voltage_trim_reg
      16'hA010,   // low_voltage_detect_config
      16'hA011,   // low_voltage_threshold
      16'hA013,   // interrupt_protect_one
      16'hA014,   // interrupt_protect_two
      16'hA025,   // protection_counter_low
      16'hA026,   // protection_counter_high
      16'hA0E1,   // breakpoint_interrupt_enable
      16'hA0EF    // debug_slave_identifier
   };

   // status field and reset values
   localparam int          STATUS_BIT_POS         = 0;
   localparam logic        SINGLE_USE_RESET       = 1'b0;
   localparam logic [7:0]  TIMED_KEY_RESET        = 8'h00;

   // timed window length in system clock periods
   localparam int          TIMED_WINDOW_CYCLES    = 256;

   typedef enum {
      KEY_IDLE,
      KEY_GOT_FIRST
   } key_state_e;

   // one cpu register access, valid for the cycle it is presented
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        xfr;
      logic [15:0] addr;
      logic [7:0]  data;
   } bus_req_s;

   // write forwarded to a guarded register
   typedef struct packed {
      logic        wr;
      logic        xfr;
      logic [15:0] addr;
      logic [7:0]  data;
   } guarded_wr_s;

endpackage

// [hw/key_sequence_detector.sv]
// two-write key sequence detector for one key register
// assumes wr_strobe is a one-cycle write to that key register on sys_clk
module key_sequence_detector
   import unlock_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       wr_strobe,
   input  wire logic [7:0] wdata,
   output logic            seq_done
);

   key_state_e state_r;
   key_state_e state_nxt;

   always_comb begin
      state_nxt = state_r;
      seq_done  = 1'b0;
      if (wr_strobe) begin
         unique case (state_r)
            KEY_IDLE: begin
               state_nxt = (wdata == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
            end
            KEY_GOT_FIRST: begin
               // any second write ends the attempt; only the exact pair grants
               state_nxt = KEY_IDLE;
               seq_done  = (wdata == KEY_SECOND);
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= KEY_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

endmodule

// [hw/window_timer.sv]
// down counter holding the timed write window open
// assumes load and clear are one-cycle pulses on sys_clk
module window_timer
   import unlock_pkg::*;
#(
   parameter int unsigned CYCLES = TIMED_WINDOW_CYCLES,
   parameter int unsigned CW     = $clog2(CYCLES + 1)
)(
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          load,
   input  wire logic          clear,
   output logic               open_r,
   output logic [CW-1:0]      remaining
);

   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;

   if (CYCLES < 1 || CW < $clog2(CYCLES + 1)) begin : g_bad_cycles
      $error("window_timer: CYCLES must be at least 1 and fit in CW bits");
   end

   assign remaining = count_r;

   always_comb begin
      count_nxt = count_r;
      if (clear) begin
         count_nxt = '0;
      end else if (load) begin
         // a repeated key restarts from the full length
         count_nxt = CW'(CYCLES);
      end else if (count_r != '0) begin
         count_nxt = count_r - 1'b1;
      end
   end

   // no time base besides sys_clk: a stopped clock freezes the window
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count_r <= '0;
         open_r  <= 1'b0;
      end else begin
         count_r <= count_nxt;
         open_r  <= (count_nxt != '0);
      end
   end

endmodule

// [hw/timed_register_unlock.sv]
// write-protection unit for critical sfr and xfr registers
// assumes the cpu presents one access per cycle on bus_req, same clock, no sync needed
// How it works
// - single-use grant after writes 0xAA then 0x55
// - next write to a single-use guarded register consumes the grant
// - reads of guarded registers are never blocked
// - single-use key guards 0xD8, 0xC6, 0x9D
// - single-use grant never times out
// - any single-use key access voids held grant
// - single-use key reads grant status in bit 0
// - timed pair opens a 256-cycle write window
// - repeated timed pair restarts the window count
// - writing 0x00 to timed key closes window
// - timed key reads window status in bit 0
// - timed key guards sfr 0x8F and 0x9F
// - timed key guards listed xfr registers 0xA000-0xA0EF
// - all state runs on cpu clock, freezes when stopped
// - single-use status resets to locked
// - timed key resets to closed
module timed_register_unlock
   import unlock_pkg::*;
#(
   parameter int unsigned WINDOW_CYCLES = TIMED_WINDOW_CYCLES
)(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire bus_req_s   bus_req,
   output guarded_wr_s     guarded_wr_r,
   output logic            wr_refused_r,
   output logic [7:0]      key_rdata_r,
   output logic            key_rvalid_r,
   output logic            single_use_unlocked_flag,
   output logic            timed_window_open_flag
);

   localparam int unsigned CW = $clog2(WINDOW_CYCLES + 1);

   if (WINDOW_CYCLES < 1) begin : g_bad_window
      $error("timed_register_unlock: WINDOW_CYCLES must be at least 1");
   end

   // address decode
   logic                       su_key_hit;
   logic                       tw_key_hit;
   logic                       su_key_access;
   logic                       su_key_wr;
   logic                       su_key_rd;
   logic                       tw_key_wr;
   logic                       tw_key_rd;
   logic                       tw_close;
   logic                       su_guarded;
   logic                       tw_guarded;
   logic [TIMED_XFR_COUNT-1:0] xfr_hits;
   logic                       su_guard_wr;
   logic                       tw_guard_wr;
   logic                       su_done;
   logic                       tw_done;
   logic                       win_open;
   logic [CW-1:0]              win_remaining;

   assign su_key_hit    = !bus_req.xfr && (bus_req.addr[7:0] == SINGLE_USE_KEY_ADDR);
   assign tw_key_hit    = !bus_req.xfr && (bus_req.addr[7:0] == TIMED_WINDOW_KEY_ADDR);
   assign su_key_wr     = bus_req.wr && su_key_hit;
   assign su_key_rd     = bus_req.rd && su_key_hit;
   assign su_key_access = su_key_wr || su_key_rd;
   assign tw_key_wr     = bus_req.wr && tw_key_hit;
   assign tw_key_rd     = bus_req.rd && tw_key_hit;
   assign tw_close      = tw_key_wr && (bus_req.data == KEY_CLOSE);

   assign su_guarded = !bus_req.xfr &&
                       (bus_req.addr[7:0] == WATCHDOG_CONTROL_ADDR ||
                        bus_req.addr[7:0] == MEMORY_CONTROL_ADDR   ||
                        bus_req.addr[7:0] == AUXILIARY_CONTROL_ADDR);

   for (genvar i = 0; i < TIMED_XFR_COUNT; i++) begin : g_xfr
      assign xfr_hits[i] = bus_req.xfr && (bus_req.addr == TIMED_XFR_ADDRS[i]);
   end

   assign tw_guarded = (|xfr_hits) ||
                       (!bus_req.xfr &&
                        (bus_req.addr[7:0] == CLOCK_SELECT_ADDR ||
                         bus_req.addr[7:0] == WAKEUP_MASK_ADDR));

   // only writes are gated; reads of guarded registers go straight to them
   assign su_guard_wr = bus_req.wr && su_guarded;
   assign tw_guard_wr = bus_req.wr && tw_guarded;

   key_sequence_detector u_single_use_seq (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .wr_strobe (su_key_wr),
      .wdata     (bus_req.data),
      .seq_done  (su_done)
   );

   key_sequence_detector u_timed_seq (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .wr_strobe (tw_key_wr),
      .wdata     (bus_req.data),
      .seq_done  (tw_done)
   );

   window_timer #(
      .CYCLES (WINDOW_CYCLES),
      .CW     (CW)
   ) u_window (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .load      (tw_done),
      .clear     (tw_close),
      .open_r    (win_open),
      .remaining (win_remaining)
   );

   assign timed_window_open_flag = win_open;

   // single-use grant and write forwarding
   logic        held_r;
   logic        held_nxt;
   guarded_wr_s guarded_wr_nxt;
   logic        wr_refused_nxt;
   logic [7:0]  key_rdata_nxt;
   logic        key_rvalid_nxt;

   always_comb begin
      held_nxt       = held_r;
      guarded_wr_nxt = '0;
      wr_refused_nxt = 1'b0;
      key_rdata_nxt  = 8'h00;
      key_rvalid_nxt = 1'b0;

      // grant wins; it cannot meet a held grant, since the 0xAA write voided it
      if (su_done) begin
         held_nxt = 1'b1;
      end else if (held_r && su_key_access) begin
         held_nxt = 1'b0;
      end else if (held_r && su_guard_wr) begin
         held_nxt = 1'b0;
      end
      // otherwise the grant stands however long it waits

      if ((su_guard_wr && held_r) || (tw_guard_wr && win_open)) begin
         guarded_wr_nxt.wr   = 1'b1;
         guarded_wr_nxt.xfr  = bus_req.xfr;
         guarded_wr_nxt.addr = bus_req.addr;
         guarded_wr_nxt.data = bus_req.data;
      end else if (su_guard_wr || tw_guard_wr) begin
         wr_refused_nxt = 1'b1;
      end

      // status reads: the value returned is the state before the access
      if (su_key_rd) begin
         key_rvalid_nxt                = 1'b1;
         key_rdata_nxt[STATUS_BIT_POS] = held_r;
      end else if (tw_key_rd) begin
         key_rvalid_nxt                = 1'b1;
         key_rdata_nxt[STATUS_BIT_POS] = win_open;
      end
   end

   // a stopped cpu clock leaves a held grant held; software must drop it first
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         held_r       <= SINGLE_USE_RESET;
         guarded_wr_r <= '0;
         wr_refused_r <= 1'b0;
         key_rdata_r  <= 8'h00;
         key_rvalid_r <= 1'b0;
      end else begin
         held_r       <= held_nxt;
         guarded_wr_r <= guarded_wr_nxt;
         wr_refused_r <= wr_refused_nxt;
         key_rdata_r  <= key_rdata_nxt;
         key_rvalid_r <= key_rvalid_nxt;
      end
   end

   assign single_use_unlocked_flag = held_r;

   // checking
   // run_r counts open cycles so a natural close can be held against the length
   logic [CW-1:0] run_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         run_r <= '0;
      end else if (tw_done || tw_close) begin
         run_r <= '0;
      end else if (win_open) begin
         run_r <= run_r + 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // a pair only counts when its detector starts idle: 0xAA 0xAA 0x55 grants nothing
   sequence s_su_pair;
      (su_key_wr && bus_req.data == KEY_FIRST && u_single_use_seq.state_r == KEY_IDLE)
      ##1 (su_key_wr && bus_req.data == KEY_SECOND);
   endsequence

   sequence s_tw_pair;
      (tw_key_wr && bus_req.data == KEY_FIRST && u_timed_seq.state_r == KEY_IDLE)
      ##1 (tw_key_wr && bus_req.data == KEY_SECOND);
   endsequence

   property p_grant_after_pair;
      s_su_pair |=> held_r;
   endproperty
   a_grant_after_pair: assert property (p_grant_after_pair)
      else $error("single-use grant missing after key pair");

   property p_grant_cause;
      $rose(held_r) |-> $past(su_key_wr && bus_req.data == KEY_SECOND);
   endproperty
   a_grant_cause: assert property (p_grant_cause)
      else $error("single-use grant without second key write");

   property p_consume;
      held_r && su_guard_wr && !su_key_access |=> !held_r && guarded_wr_r.wr;
   endproperty
   a_consume: assert property (p_consume)
      else $error("guarded write did not consume the grant");

   property p_void;
      held_r && su_key_access |=> !held_r;
   endproperty
   a_void: assert property (p_void)
      else $error("key register access did not void the grant");

   property p_no_expire;
      held_r && !su_key_access && !su_guard_wr |=> held_r;
   endproperty
   a_no_expire: assert property (p_no_expire)
      else $error("single-use grant dropped without cause");

   property p_su_status;
      su_key_rd |=> key_rvalid_r && key_rdata_r == {7'h00, $past(held_r)};
   endproperty
   a_su_status: assert property (p_su_status)
      else $error("single-use key read returned wrong status");

   property p_window_opens;
      s_tw_pair |=> win_open && win_remaining == CW'(WINDOW_CYCLES);
   endproperty
   a_window_opens: assert property (p_window_opens)
      else $error("timed window not opened at full length");

   property p_window_length;
      $fell(win_open) && !$past(tw_close) && !$past(tw_done) |-> run_r == CW'(WINDOW_CYCLES);
   endproperty
   a_window_length: assert property (p_window_length)
      else $error("timed window closed after wrong cycle count");

   property p_close;
      tw_close |=> !win_open;
   endproperty
   a_close: assert property (p_close)
      else $error("timed window still open after close write");

   property p_tw_status;
      tw_key_rd |=> key_rvalid_r && key_rdata_r == {7'h00, $past(win_open)};
   endproperty
   a_tw_status: assert property (p_tw_status)
      else $error("timed key read returned wrong status");

   property p_refuse;
      (su_guard_wr && !held_r && !(tw_guard_wr && win_open)) ||
      (tw_guard_wr && !win_open && !(su_guard_wr && held_r))
         |=> !guarded_wr_r.wr && wr_refused_r;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("unpermitted guarded write was forwarded");

   property p_read_free;
      bus_req.rd |=> !wr_refused_r && !guarded_wr_r.wr;
   endproperty
   a_read_free: assert property (p_read_free)
      else $error("register read produced a write result");

   // writes outside the guarded lists must pass by without any result
   property p_unguarded_quiet;
      bus_req.wr && !su_guarded && !tw_guarded |=> !wr_refused_r && !guarded_wr_r.wr;
   endproperty
   a_unguarded_quiet: assert property (p_unguarded_quiet)
      else $error("write to an unguarded register produced a result");

   property p_timed_pass;
      tw_guard_wr && win_open |=> guarded_wr_r.wr && guarded_wr_r.addr == $past(bus_req.addr);
   endproperty
   a_timed_pass: assert property (p_timed_pass)
      else $error("write inside timed window not forwarded");

   property p_single_pass;
      su_guard_wr && held_r |=> guarded_wr_r.wr && guarded_wr_r.data == $past(bus_req.data);
   endproperty
   a_single_pass: assert property (p_single_pass)
      else $error("write with single-use grant not forwarded");

endmodule

// [dv/cpu_core_model.sv]
// cpu core model: issues queued register accesses, one per cycle
// assumes the block samples bus_req on the rising edge of sys_clk
module cpu_core_model
   import unlock_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   output bus_req_s  bus_req
);
   timeunit 1ns;
   timeprecision 1ps;

   bus_req_s pend_q[$];

   initial bus_req = '0;

   // driven on the falling edge so the rising edge always sees a settled access
   always @(negedge sys_clk) begin
      if (!sys_rst && pend_q.size() > 0) begin
         bus_req <= pend_q.pop_front();
      end else begin
         bus_req <= '0;
      end
   end

   task automatic wr(input logic xfr, input logic [15:0] addr, input logic [7:0] data);
      pend_q.push_back('{1'b1, 1'b0, xfr, addr, data});
   endtask

   task automatic rd(input logic [15:0] addr);
      pend_q.push_back('{1'b0, 1'b1, 1'b0, addr, 8'h00});
   endtask

   task automatic nop(input int n);
      repeat (n) pend_q.push_back('0);
   endtask

   // both key registers want this ordered pair as two consecutive writes
   task automatic key_pair(input logic [7:0] key_addr);
      wr(1'b0, {8'h00, key_addr}, KEY_FIRST);
      wr(1'b0, {8'h00, key_addr}, KEY_SECOND);
   endtask

   // careful software shuts the window once its guarded updates are done
   task automatic close_window();
      wr(1'b0, {8'h00, TIMED_WINDOW_KEY_ADDR}, KEY_CLOSE);
   endtask

   // returns one rising edge after the one that takes the last queued access
   task automatic drain();
      while (pend_q.size() > 0) @(posedge sys_clk);
      @(posedge sys_clk);
   endtask
endmodule

// [dv/timed_register_unlock_tb_top.sv]
// self-checking bench for the timed register unlock unit
// assumes cpu_core_model drives the bus; results are matched against a note queue
module timed_register_unlock_tb_top import unlock_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // short window keeps the run brief; every expectation is derived from it
   localparam int unsigned NWIN = 8;

   typedef struct packed {
      logic [1:0]  kind;
      logic        xfr;
      logic [15:0] addr;
      logic [7:0]  data;
   } note_s;

   logic        sys_clk;
   logic        sys_rst;
   logic        clk_run;
   bus_req_s    bus_req;
   guarded_wr_s guarded_wr_r;
   logic        wr_refused_r;
   logic [7:0]  key_rdata_r;
   logic        key_rvalid_r;
   logic        single_use_unlocked_flag;
   logic        timed_window_open_flag;
   logic [1:0]  flags;
   int          err_total;
   int          num_checks;
   int          seed;
   note_s       note_q[$];
   note_s       seen;
   logic [7:0]  d;
   logic [7:0]  su_addr [3] = '{WATCHDOG_CONTROL_ADDR, MEMORY_CONTROL_ADDR,
                                 AUXILIARY_CONTROL_ADDR};
   logic [7:0]  g_addr  [5] = '{WATCHDOG_CONTROL_ADDR, MEMORY_CONTROL_ADDR,
                                 AUXILIARY_CONTROL_ADDR, CLOCK_SELECT_ADDR, WAKEUP_MASK_ADDR};

   assign flags = {single_use_unlocked_flag, timed_window_open_flag};

   cpu_core_model cpu (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req));

   timed_register_unlock #(.WINDOW_CYCLES(NWIN)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .guarded_wr_r(guarded_wr_r), .wr_refused_r(wr_refused_r),
      .key_rdata_r(key_rdata_r), .key_rvalid_r(key_rvalid_r),
      .single_use_unlocked_flag(single_use_unlocked_flag),
      .timed_window_open_flag(timed_window_open_flag));

   // clk_run lets a scenario freeze the clock as idle or stop mode would
   initial begin
      sys_clk = 1'b0;
      forever begin
         #4;
         if (clk_run) sys_clk = ~sys_clk;
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [1:0] got, input logic [1:0] want, input string what);
      num_checks++;
      if (got !== want) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   // guarded write: ok=1 expects forwarding, ok=0 expects a refusal pulse
   task automatic gw(input logic ok, input logic xfr, input logic [15:0] a,
                     input logic [7:0] dv);
      cpu.wr(xfr, a, dv);
      if (ok) note_q.push_back('{2'h1, xfr, a, dv});
      else note_q.push_back('{2'h2, 1'b0, 16'h0000, 8'h00});
   endtask

   task automatic kr(input logic [7:0] a, input logic st);
      cpu.rd({8'h00, a});
      note_q.push_back('{2'h3, 1'b0, 16'h0000, {7'h00, st}});
   endtask

   task automatic end_test(input string name);
      cpu.drain();
      repeat (2) @(negedge sys_clk);
      $display("test %s done", name);
   endtask

   // every result pulse must match the oldest note, so extra pulses are caught too
   always @(negedge sys_clk) begin
      if (sys_rst === 1'b0 && (guarded_wr_r.wr === 1'b1 || wr_refused_r === 1'b1
                               || key_rvalid_r === 1'b1)) begin
         seen = '0;
         if (guarded_wr_r.wr === 1'b1)
            seen = '{2'h1, guarded_wr_r.xfr, guarded_wr_r.addr, guarded_wr_r.data};
         else if (wr_refused_r === 1'b1) seen.kind = 2'h2;
         else seen = '{2'h3, 1'b0, 16'h0000, key_rdata_r};
         num_checks++;
         if (note_q.size() == 0) begin
            err_total++;
            $display("unexpected at %0t: result with no pending note", $time);
         end else if (note_q.pop_front() !== seen) begin
            err_total++;
            $display("unexpected at %0t: result %h differs from note", $time, seen);
         end
      end
   end

   initial begin
      #100000;
      err_total++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end

   initial begin
      seed = 11734;
      clk_run = 1'b1;
      err_total = 0;
      num_checks = 0;
      sys_rst = 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      chk(flags, 2'h0, "flags not clear after reset");
      kr(SINGLE_USE_KEY_ADDR, 1'b0);
      kr(TIMED_WINDOW_KEY_ADDR, 1'b0);
      end_test("reset");
      foreach (su_addr[i]) begin
         d = 8'($random(seed));
         cpu.key_pair(SINGLE_USE_KEY_ADDR);
         gw(1'b1, 1'b0, {8'h00, su_addr[i]}, d);
         gw(1'b0, 1'b0, {8'h00, su_addr[i]}, ~d);
      end
      cpu.key_pair(SINGLE_USE_KEY_ADDR);
      gw(1'b0, 1'b0, {8'h00, CLOCK_SELECT_ADDR}, 8'h3C);
      gw(1'b1, 1'b0, {8'h00, MEMORY_CONTROL_ADDR}, 8'hC3);
      end_test("single use");
      cpu.key_pair(SINGLE_USE_KEY_ADDR);
      cpu.nop(40);
      gw(1'b1, 1'b0, {8'h00, WATCHDOG_CONTROL_ADDR}, 8'h01);
      cpu.key_pair(SINGLE_USE_KEY_ADDR);
      kr(SINGLE_USE_KEY_ADDR, 1'b1);
      gw(1'b0, 1'b0, {8'h00, WATCHDOG_CONTROL_ADDR}, 8'h02);
      cpu.key_pair(SINGLE_USE_KEY_ADDR);
      cpu.wr(1'b0, {8'h00, SINGLE_USE_KEY_ADDR}, 8'h12);
      kr(SINGLE_USE_KEY_ADDR, 1'b0);
      for (int i = 0; i < 2; i++) begin
         d = (i == 0) ? KEY_FIRST : (8'($random(seed)) | 8'h80);
         cpu.wr(1'b0, {8'h00, SINGLE_USE_KEY_ADDR}, KEY_FIRST);
         cpu.wr(1'b0, {8'h00, SINGLE_USE_KEY_ADDR}, d);
         cpu.wr(1'b0, {8'h00, SINGLE_USE_KEY_ADDR}, KEY_SECOND);
         gw(1'b0, 1'b0, {8'h00, AUXILIARY_CONTROL_ADDR}, 8'h04);
      end
      end_test("grant lifetime");
      cpu.key_pair(TIMED_WINDOW_KEY_ADDR);
      for (int i = 0; i < NWIN; i++)
         gw(1'b1, 1'b0, {8'h00, i[0] ? WAKEUP_MASK_ADDR : CLOCK_SELECT_ADDR},
            8'($random(seed)));
      gw(1'b0, 1'b0, {8'h00, CLOCK_SELECT_ADDR}, 8'h5A);
      cpu.key_pair(TIMED_WINDOW_KEY_ADDR);
      cpu.nop(4);
      cpu.key_pair(TIMED_WINDOW_KEY_ADDR);
      for (int i = 0; i < NWIN; i++)
         gw(1'b1, 1'b0, {8'h00, WAKEUP_MASK_ADDR}, 8'($random(seed)));
      gw(1'b0, 1'b0, {8'h00, WAKEUP_MASK_ADDR}, 8'hA5);
      cpu.key_pair(TIMED_WINDOW_KEY_ADDR);
      kr(TIMED_WINDOW_KEY_ADDR, 1'b1);
      cpu.close_window();
      kr(TIMED_WINDOW_KEY_ADDR, 1'b0);
      gw(1'b0, 1'b0, {8'h00, WAKEUP_MASK_ADDR}, 8'h0F);
      end_test("timed window");
      foreach (TIMED_XFR_ADDRS[i]) begin
         cpu.key_pair(TIMED_WINDOW_KEY_ADDR);
         cpu.wr(1'b1, 16'hA003, 8'h77);
         gw(1'b1, 1'b1, TIMED_XFR_ADDRS[i], 8'($random(seed)));
      end
      cpu.close_window();
      gw(1'b0, 1'b1, TIMED_XFR_ADDRS[0], 8'h11);
      end_test("extended registers");
      cpu.key_pair(TIMED_WINDOW_KEY_ADDR);
      cpu.key_pair(SINGLE_USE_KEY_ADDR);
      cpu.drain();
      clk_run = 1'b0;
      #400;
      clk_run = 1'b1;
      @(negedge sys_clk);
      chk(flags, 2'h3, "state lost while clock stopped");
      gw(1'b1, 1'b0, {8'h00, MEMORY_CONTROL_ADDR}, 8'h66);
      gw(1'b1, 1'b0, {8'h00, CLOCK_SELECT_ADDR}, 8'h99);
      cpu.close_window();
      // careful software drops both permissions before it stops the clock
      cpu.key_pair(TIMED_WINDOW_KEY_ADDR);
      cpu.key_pair(SINGLE_USE_KEY_ADDR);
      kr(SINGLE_USE_KEY_ADDR, 1'b1);
      cpu.close_window();
      cpu.drain();
      clk_run = 1'b0;
      #400;
      clk_run = 1'b1;
      @(negedge sys_clk);
      chk(flags, 2'h0, "permission open across a stop after cancel");
      end_test("clock stop");
      for (int i = 0; i < 8; i++)
         gw(1'b0, 1'b0, {8'h00, g_addr[$unsigned($random(seed)) % 5]},
            8'($random(seed)));
      cpu.rd({8'h00, WATCHDOG_CONTROL_ADDR});
      cpu.rd({8'h00, CLOCK_SELECT_ADDR});
      end_test("refusals");
      chk(flags, 2'h0, "flags not clear at end");
      chk({1'b0, note_q.size() != 0}, 2'h0, "notes left without a result");
      end_sim();
   end
endmodule
